/* File: vdcfg_consts.vh */
`ifndef VDCFG_CONSTS_VH
`define VDCFG_CONSTS_VH

// byte addresses of the register words
`define ADDR_VD_CTRL 8'h9c
`define ADDR_VD_WORD 8'ha0
`define ADDR_VENDOR 8'ha4
`define ADDR_TEST0 8'ha8
`define ADDR_TEST1 8'hac
`define ADDR_TIMERS 8'hb0

// fixed capability contents
`define VD_CAP_ID 8'h03
`define VD_NEXT_PTR 8'ha4
`define VENDOR_CAP_ID 8'h09
`define VENDOR_NEXT_PTR 8'he0
`define VENDOR_LENGTH 16'h0028

// test word reset values
`define TEST0_RST 32'h04001060
`define TEST1_RST 32'h04000271

// capability header fields
`define ID_MSB 7
`define ID_LSB 0
`define PTR_MSB 15
`define PTR_LSB 8
`define LEN_MSB 31
`define LEN_LSB 16

// control word fields
`define GO_BIT 16
`define WSEL_BIT 17
`define IDX_LSB 18
`define IDX_MSB 22

// timer override fields
`define REPLAY_LSB 0
`define REPLAY_MSB 11
`define REPLAY_EN_BIT 12
`define ACK_LSB 16
`define ACK_MSB 29
`define ACK_EN_BIT 30

`endif

/* File: vd_table_port.v */
`timescale 1ns/10ps
// sequences one table access against the external store: request strobe,
// then wait for the store's done; read data is captured on done.
module vd_table_port (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // from register bank
  input wire start,
  input wire write_sel,
  input wire [4:0] index,
  input wire [31:0] wdata,
  // to register bank
  output reg done_r,
  output reg [31:0] rdata_r,
  // to store
  output reg req_r,
  output reg req_write_r,
  output reg [4:0] req_index_r,
  output reg [31:0] req_wdata_r,
  // from store
  input wire st_done,
  input wire [31:0] st_rdata
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg state_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      done_r <= 1'b0;
      rdata_r <= 32'h00000000;
      req_r <= 1'b0;
      req_write_r <= 1'b0;
      req_index_r <= 5'h00;
      req_wdata_r <= 32'h00000000;
    end else begin
      done_r <= 1'b0;
      req_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            req_r <= 1'b1;
            req_write_r <= write_sel;
            req_index_r <= index;
            req_wdata_r <= wdata;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (st_done) begin
            if (!req_write_r)
              rdata_r <= st_rdata;
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

/* File: vital_data_and_link_timer_cfg.v */
`timescale 1ns/10ps
// Function
// - vital data capability id reads 03h
// - vital data next pointer reads a4h
// - go bit starts access, hardware clears it
// - direction bit: zero reads, one writes
// - five-bit dword index addresses the table
// - data word returns last fetched dword
// - write stores data word into table
// - vendor capability id reads 09h
// - vendor next pointer reads e0h
// - vendor length field reads 28h
// - replay value 12 bits, resets zero
// - replay override bit selects user value
// - ack latency value 14 bits, resets zero
// - ack override bit selects user value
// - timer defaults may come from autoload
`include "vdcfg_consts.vh"
module vital_data_and_link_timer_cfg (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // external table store
  output reg tbl_req,
  output reg tbl_write,
  output reg [4:0] tbl_index,
  output reg [31:0] tbl_wdata,
  input wire tbl_done,
  input wire [31:0] tbl_rdata,
  // autoload of timer defaults, from the eeprom loader
  input wire load_valid,
  input wire [31:0] load_timers,
  // link layer timer selects
  output reg [11:0] replay_user,
  output reg replay_override,
  output reg [13:0] ack_user,
  output reg ack_override
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg go_r;
  reg go_nxt;
  reg wsel_r;
  reg [4:0] idx_r;
  reg [31:0] word_r;
  reg [31:0] test0_r;
  reg [31:0] test1_r;
  reg [11:0] replay_r;
  reg replay_en_r;
  reg [13:0] ack_r;
  reg ack_en_r;
  reg start_r;
  reg load_meta_r;
  reg load_sync_r;
  reg load_seen_r;
  reg [31:0] load_t_meta_r;
  reg [31:0] load_t_sync_r;
  reg [31:0] prdata_nxt;
  reg hit;

  wire wr_en;
  wire done;
  wire [31:0] fetched;

  // a write lands only at the edge that ends the access
  assign wr_en = psel & penable & pwrite & pready;

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `ADDR_VD_CTRL) || (a == `ADDR_VD_WORD) ||
                  (a == `ADDR_VENDOR) || (a == `ADDR_TEST0) ||
                  (a == `ADDR_TEST1) || (a == `ADDR_TIMERS);
    end
  endfunction

  // ----------------------------------------------------------------
  // table access sequencer
  // ----------------------------------------------------------------
  wire req_w;
  wire req_write_w;
  wire [4:0] req_index_w;
  wire [31:0] req_wdata_w;

  vd_table_port u_port (
    .clk(clk),
    .rst_n(rst_n),
    .start(start_r),
    .write_sel(wsel_r),
    .index(idx_r),
    .wdata(word_r),
    .done_r(done),
    .rdata_r(fetched),
    .req_r(req_w),
    .req_write_r(req_write_w),
    .req_index_r(req_index_w),
    .req_wdata_r(req_wdata_w),
    .st_done(tbl_done),
    .st_rdata(tbl_rdata)
  );

  // ----------------------------------------------------------------
  // autoload strobe (from the loader's domain), synchronised
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_meta_r <= 1'b0;
      load_sync_r <= 1'b0;
      load_seen_r <= 1'b0;
      load_t_meta_r <= 32'h00000000;
      load_t_sync_r <= 32'h00000000;
    end else begin
      load_meta_r <= load_valid;
      load_sync_r <= load_meta_r;
      load_seen_r <= load_sync_r;
      // word is held stable by the loader while its strobe is high
      load_t_meta_r <= load_timers;
      load_t_sync_r <= load_t_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // go bit: hardware clear happens once done, writes while busy ignored
  // ----------------------------------------------------------------
  always @* begin
    go_nxt = go_r;
    if (done)
      go_nxt = 1'b0;
    else if (wr_en && paddr == `ADDR_VD_CTRL && !go_r)
      go_nxt = pwdata[`GO_BIT];
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      go_r <= 1'b0;
      wsel_r <= 1'b0;
      idx_r <= 5'h00;
      word_r <= 32'h00000000;
      test0_r <= `TEST0_RST;
      test1_r <= `TEST1_RST;
      replay_r <= 12'h000;
      replay_en_r <= 1'b0;
      ack_r <= 14'h0000;
      ack_en_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      go_r <= go_nxt;
      start_r <= go_nxt & ~go_r;
      // control fields are frozen while an access runs so the
      // sequencer sees a stable index and direction
      if (wr_en && paddr == `ADDR_VD_CTRL && !go_r) begin
        wsel_r <= pwdata[`WSEL_BIT];
        idx_r <= pwdata[`IDX_MSB:`IDX_LSB];
      end
      if (done && !wsel_r)
        word_r <= fetched;
      else if (wr_en && paddr == `ADDR_VD_WORD && !go_r)
        word_r <= pwdata;
      if (wr_en && paddr == `ADDR_TEST0)
        test0_r <= pwdata;
      if (wr_en && paddr == `ADDR_TEST1)
        test1_r <= pwdata;
      if (load_sync_r && !load_seen_r) begin
        replay_r <= load_t_sync_r[`REPLAY_MSB:`REPLAY_LSB];
        replay_en_r <= load_t_sync_r[`REPLAY_EN_BIT];
        ack_r <= load_t_sync_r[`ACK_MSB:`ACK_LSB];
        ack_en_r <= load_t_sync_r[`ACK_EN_BIT];
      end else if (wr_en && paddr == `ADDR_TIMERS) begin
        replay_r <= pwdata[`REPLAY_MSB:`REPLAY_LSB];
        replay_en_r <= pwdata[`REPLAY_EN_BIT];
        ack_r <= pwdata[`ACK_MSB:`ACK_LSB];
        ack_en_r <= pwdata[`ACK_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @* begin
    prdata_nxt = 32'h00000000;
    hit = is_mapped(paddr);
    case (paddr)
      `ADDR_VD_CTRL: begin
        prdata_nxt[`ID_MSB:`ID_LSB] = `VD_CAP_ID;
        prdata_nxt[`PTR_MSB:`PTR_LSB] = `VD_NEXT_PTR;
        prdata_nxt[`GO_BIT] = go_r;
        prdata_nxt[`WSEL_BIT] = wsel_r;
        prdata_nxt[`IDX_MSB:`IDX_LSB] = idx_r;
      end
      `ADDR_VD_WORD: prdata_nxt = word_r;
      `ADDR_VENDOR: begin
        prdata_nxt[`ID_MSB:`ID_LSB] = `VENDOR_CAP_ID;
        prdata_nxt[`PTR_MSB:`PTR_LSB] = `VENDOR_NEXT_PTR;
        prdata_nxt[`LEN_MSB:`LEN_LSB] = `VENDOR_LENGTH;
      end
      `ADDR_TEST0: prdata_nxt = test0_r;
      `ADDR_TEST1: prdata_nxt = test1_r;
      `ADDR_TIMERS: begin
        prdata_nxt[`REPLAY_MSB:`REPLAY_LSB] = replay_r;
        prdata_nxt[`REPLAY_EN_BIT] = replay_en_r;
        prdata_nxt[`ACK_MSB:`ACK_LSB] = ack_r;
        prdata_nxt[`ACK_EN_BIT] = ack_en_r;
      end
      default: prdata_nxt = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // registered bus answer and outputs
  // one wait state: pready rises in the second access cycle
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tbl_req <= 1'b0;
      tbl_write <= 1'b0;
      tbl_index <= 5'h00;
      tbl_wdata <= 32'h00000000;
      replay_user <= 12'h000;
      replay_override <= 1'b0;
      ack_user <= 14'h0000;
      ack_override <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel && penable && !pready && !pwrite)
        prdata <= prdata_nxt;
      tbl_req <= req_w;
      tbl_write <= req_write_w;
      tbl_index <= req_index_w;
      tbl_wdata <= req_wdata_w;
      replay_user <= replay_r;
      replay_override <= replay_en_r;
      ack_user <= ack_r;
      ack_override <= ack_en_r;
    end
  end

endmodule

/* File: vdcfg_chk.sv */
`timescale 1ns/10ps
module vdcfg_chk (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // table and timers
  input wire tbl_req,
  input wire tbl_write,
  input wire [4:0] tbl_index,
  input wire tbl_done,
  input wire [11:0] replay_user,
  input wire replay_override,
  input wire [13:0] ack_user,
  input wire ack_override
);
  reg busy_r;
  reg done_d_r;
  wire acc = psel && penable && pready;
  wire go_w = acc && pwrite && paddr == 8'h9c && pwdata[16] && !busy_r;
  wire map_w = paddr inside {8'h9c, 8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hb0};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      done_d_r <= 1'b0;
    end else begin
      done_d_r <= tbl_done;
      if (go_w)
        busy_r <= 1'b1;
      else if (done_d_r)
        busy_r <= 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_go_launch: assert property (go_w |-> ##3 tbl_req &&
    tbl_write == $past(pwdata[17], 3) && tbl_index == $past(pwdata[22:18], 3))
    else $error("table request missing or wrong");
  a_req_cause: assert property (tbl_req |-> $past(go_w, 3))
    else $error("table request without go");
  a_req_once: assert property (tbl_req |=> !tbl_req [*2])
    else $error("table request repeated");
  a_idx_hold: assert property (busy_r && !tbl_req && !$past(go_w)
    |-> $stable(tbl_index)) else $error("table index moved");
  a_timer_copy: assert property (acc && pwrite && paddr == 8'hb0
    |-> ##2 replay_user == $past(pwdata[11:0], 2) &&
    replay_override == $past(pwdata[12], 2) &&
    ack_user == $past(pwdata[29:16], 2) && ack_override == $past(pwdata[30], 2))
    else $error("timer outputs wrong");
  a_reset_zero: assert property ($rose(rst_n) |->
    replay_user == 0 && ack_user == 0 && !replay_override && !ack_override)
    else $error("timer outputs not zero after reset");
  a_err_map: assert property (acc |-> pslverr == !map_w)
    else $error("error response wrong");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  cover property (go_w && pwdata[17]);
  cover property (go_w && !pwdata[17]);
  cover property (acc && pslverr);
endmodule

/* File: vd_store_model.sv */
`timescale 1ns/10ps
module vd_store_model (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // request
  input wire tbl_req,
  input wire tbl_write,
  input wire [4:0] tbl_index,
  input wire [31:0] tbl_wdata,
  input wire [3:0] lat,
  // answer
  output reg tbl_done,
  output reg [31:0] tbl_rdata
);
  reg [31:0] mem [0:31];
  reg [3:0] cnt_r;
  reg busy_r;
  initial for (int i = 0; i < 32; i++) mem[i] = 32'h5a000000 + i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      tbl_done <= 1'b0;
      tbl_rdata <= 32'h0;
    end else begin
      tbl_done <= 1'b0;
      // data is only held with done, so it toggles otherwise
      tbl_rdata <= ~tbl_rdata;
      if (tbl_req) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
      end else if (busy_r && cnt_r != 0)
        cnt_r <= cnt_r - 1;
      else if (busy_r) begin
        busy_r <= 1'b0;
        tbl_done <= 1'b1;
        if (tbl_write)
          mem[tbl_index] <= tbl_wdata;
        else
          tbl_rdata <= mem[tbl_index];
      end
    end
  end
endmodule

/* File: vital_data_and_link_timer_cfg_tb_top.sv */
`timescale 1ns/10ps
module vital_data_and_link_timer_cfg_tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg load_valid = 1'b0;
  reg [31:0] load_timers = 32'h0;
  reg [3:0] lat = 4'h0;
  wire [31:0] prdata, tbl_wdata, tbl_rdata;
  wire pready, pslverr, tbl_req, tbl_write, tbl_done;
  wire replay_override, ack_override;
  wire [4:0] tbl_index;
  wire [11:0] replay_user;
  wire [13:0] ack_user;
  reg [31:0] q;
  reg e;
  int num_errors = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  vital_data_and_link_timer_cfg dut (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tbl_req, .tbl_write,
    .tbl_index, .tbl_wdata, .tbl_done, .tbl_rdata, .load_valid, .load_timers,
    .replay_user, .replay_override, .ack_user, .ack_override);
  vd_store_model store (.clk, .rst_n, .tbl_req, .tbl_write, .tbl_index,
    .tbl_wdata, .lat, .tbl_done, .tbl_rdata);
  // ----
  // access tasks
  // ----
  task summarize;
    begin
      $display("errors %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run++;
      if (seen !== exp) begin
        num_errors++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    int n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
        num_errors++;
        summarize;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] x);
    begin
      xfer(1'b0, a, 32'h0);
      chk(q, x);
    end
  endtask
  // go must drop within a bounded number of polls
  task poll;
    int n;
    begin
      n = 0;
      do begin
        xfer(1'b0, 8'h9c, 32'h0);
        n++;
      end while (q[16] !== 1'b0 && n < 40);
      chk(q[16], 32'h0);
    end
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h9c, 32'h0000a403);
    rd(8'ha0, 32'h0);
    rd(8'ha4, 32'h0028e009);
    rd(8'ha8, 32'h04001060);
    rd(8'hac, 32'h04000271);
    rd(8'hb0, 32'h0);
    xfer(1'b1, 8'ha4, 32'hffffffff);
    rd(8'ha4, 32'h0028e009);
    xfer(1'b1, 8'hb0, 32'hffffffff);
    rd(8'hb0, 32'h7fff1fff);
    chk({ack_override, ack_user, replay_override, replay_user},
      32'h0fffffff);
    xfer(1'b1, 8'hb0, 32'h40001000);
    // outputs follow the register one cycle later
    @(posedge clk);
    chk({ack_override, ack_user, replay_override, replay_user},
      32'h08001000);
    rd(8'hb4, 32'h0);
    chk(e, 32'h1);
    lat <= 4'h6;
    xfer(1'b1, 8'ha0, 32'hdeadbeef);
    xfer(1'b1, 8'h9c, 32'h00170000);
    xfer(1'b1, 8'ha0, 32'h11111111);
    poll;
    rd(8'ha0, 32'hdeadbeef);
    xfer(1'b1, 8'h9c, 32'h000d0000);
    poll;
    rd(8'ha0, 32'h5a000003);
    lat <= 4'h0;
    xfer(1'b1, 8'h9c, 32'h00150000);
    poll;
    rd(8'ha0, 32'hdeadbeef);
    load_timers <= 32'hcabc3123;
    load_valid <= 1'b1;
    repeat (6) @(posedge clk);
    load_valid <= 1'b0;
    rd(8'hb0, 32'h4abc1123);
    chk(replay_user, 32'h123);
    summarize;
  end
endmodule
bind vital_data_and_link_timer_cfg vdcfg_chk chk_i (.clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .tbl_req, .tbl_write,
  .tbl_index, .tbl_done, .replay_user, .replay_override, .ack_user,
  .ack_override);
